/* File: shared/fcs_cfg.svh */
// fcs_cfg.svh: register map, field positions and counts of the flash command/status block
// assumes: included by bare name; AHB-Lite byte address = register index * 4
//
// Behaviour
// RL1 - index register low field selects command object word; upper bits read zero
// RL2 - interrupt enable set: raise interrupt whenever command done flag is set
// RL3 - writing one to done flag launches command; flag stays low until finish
// RL4 - access error set on command sequence violation or illegal command
// RL5 - while access error set, done flag write neither clears nor launches
// RL6 - writing one clears access error; writing zero leaves it
// RL7 - protection violation set when program/erase targets a protected address
// RL8 - writing one clears protection violation; writing zero has no effect
// RL9 - while protection violation set, no launch and no new sequence start
// RL10 - busy bit reads one while a command executes, zero when idle
// RL11 - completion status bits set on error during command or reset sequence
// RL12 - normal mode: protection writes accepted only if protected region grows
// RL13 - background debug mode: protection bits writable without restriction
// RL14 - reset sequence loads protection register from stored byte at 0x40D
// RL15 - whole-block erase rejected if any sector of the block is protected
// RL16 - mode bit: zero gives unprotected range, one gives protected range
// RL17 - interrupt held while enable bit and done flag are both one
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// register indices, byte address is four times these
`define FCS_IDX_CMD_INDEX  16'h1832
`define FCS_IDX_CONFIG     16'h1834
`define FCS_IDX_STATUS     16'h1836
`define FCS_IDX_PROTECT    16'h1838
`define FCS_IDX_CMD_DATA   16'h183A
`define FCS_IDX_IRQ_STAT   16'h1840
`define FCS_IDX_IRQ_MASK   16'h1841
// field positions
`define FCS_BIT_IRQ_EN     7
`define FCS_BIT_DONE       7
`define FCS_BIT_ACCESS_ERROR_FLAG     5
`define FCS_BIT_PVIOL      4
`define FCS_BIT_BUSY       3
`define FCS_BIT_MODE       7
`define FCS_BIT_HIDIS      5
`define FCS_BIT_HSZ_HI     4
`define FCS_BIT_HSZ_LO     3
`define FCS_BIT_EV_DONE    0
`define FCS_BIT_EV_ACCESS_ERROR_FLAG  1
`define FCS_BIT_EV_PVIOL   2
`define FCS_PROT_WMASK     8'hB8
// sizes, reset values, constants
`define FCS_WORDS          6
`define FCS_IDX_W          3
`define FCS_STAT_W         2
`define FCS_EV_W           3
`define FCS_PROT_NV_ADDR   16'h040D
`define FCS_HIGH_TOP       16'h7FFF
`define FCS_HIGH_END       17'h08000
`define FCS_RANGE_BASE     17'h00400
`define FCS_CMD_CYCLES     16
`define FCS_HSIZE_WORD     3'h2
// command codes of the command object word 0 high byte
`define FCS_CMD_PROGRAM    8'h06
`define FCS_CMD_ERASE_BLK  8'h09
`define FCS_CMD_ERASE_SEC  8'h0A
`endif

/* File: shared/fcs_pkg.sv */
// fcs_pkg.sv: state types of the flash command/status block
// assumes: used with package-qualified names only
package fcs_pkg;
	// start-up sequence of the register side
	typedef enum logic {
		FCS_INIT_LOAD = 1'b0,
		FCS_INIT_RUN  = 1'b1
	} fcs_init_type;
	// command execution states
	typedef enum logic [1:0] {
		FCS_ENG_IDLE = 2'b00,
		FCS_ENG_EXEC = 2'b01
	} fcs_eng_type;
endpackage

/* File: shared/fcs_cmd_if.sv */
// fcs_cmd_if.sv: launch and result signals between register side and command engine
// assumes: one clock; all signals driven from flip-flops of their owner, except flashFault, which passes the top input straight through
`timescale 1ns/1ps
interface fcs_cmd_if;
	logic        launch;
	logic [7:0]  cmdCode;
	logic [15:0] cmdAddr;
	logic [7:0]  protByte;
	logic        flashFault;
	logic        done;
	logic        access_error_flag;
	logic        protViol;
	logic        fault;
	logic        busy;
	// register side
	modport ctrl (
		output launch, cmdCode, cmdAddr, protByte, flashFault,
		input  done, access_error_flag, protViol, fault, busy
	);
	// engine side
	modport eng (
		input  launch, cmdCode, cmdAddr, protByte, flashFault,
		output done, access_error_flag, protViol, fault, busy
	);
endinterface // fcs_cmd_if

/* File: verilog/fcs_cmd_engine.sv */
// fcs_cmd_engine.sv: decodes a launched command, checks protection, times execution
// assumes: launch is a one-cycle pulse, never given while busy
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_cmd_engine #(
	parameter int          CMD_CYCLES = `FCS_CMD_CYCLES,
	parameter logic [16:0] RANGE_BASE = `FCS_RANGE_BASE
) (
	// clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// link to register side
	fcs_cmd_if.eng   cmd
);
	fcs_pkg::fcs_eng_type state_q;
	logic [15:0]          count_q;
	logic                 rangeDis;
	logic                 protMode;
	logic [16:0]          rangeSize;
	logic [16:0]          lowBound;
	logic                 inRange;
	logic                 addrProt;
	logic                 blockProt;
	logic                 legal;

	// protected-range decode, anchored at the top of the high range
	assign rangeDis  = cmd.protByte[`FCS_BIT_HIDIS];
	assign protMode  = cmd.protByte[`FCS_BIT_MODE];
	assign rangeSize = RANGE_BASE << cmd.protByte[`FCS_BIT_HSZ_HI:`FCS_BIT_HSZ_LO];
	assign lowBound  = `FCS_HIGH_END - rangeSize;
	assign inRange   = !rangeDis && ({1'b0, cmd.cmdAddr} >= lowBound)
		&& (cmd.cmdAddr <= `FCS_HIGH_TOP);
	assign addrProt  = protMode ? inRange : !inRange; // RL16
	// mode 0 always leaves some of the block protected, so block erase needs mode 1
	assign blockProt = protMode ? !rangeDis : 1'b1; // RL15
	assign legal     = (cmd.cmdCode == `FCS_CMD_PROGRAM)
		|| (cmd.cmdCode == `FCS_CMD_ERASE_BLK)
		|| (cmd.cmdCode == `FCS_CMD_ERASE_SEC);

	////////////////////////////////////////////////////////////////////////////
	// launch check and execution timer; results are one-cycle pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q      <= fcs_pkg::FCS_ENG_IDLE;
			count_q      <= 16'h0000;
			cmd.busy     <= 1'b0;
			cmd.done     <= 1'b0;
			cmd.access_error_flag   <= 1'b0;
			cmd.protViol <= 1'b0;
			cmd.fault    <= 1'b0;
		end else if (ce) begin
			cmd.done     <= 1'b0;
			cmd.access_error_flag   <= 1'b0;
			cmd.protViol <= 1'b0;
			cmd.fault    <= 1'b0;
			case (state_q)
				fcs_pkg::FCS_ENG_IDLE: begin
					if (cmd.launch) begin
						if (!legal) begin
							cmd.done   <= 1'b1;
							cmd.access_error_flag <= 1'b1; // RL4
						end else if ((cmd.cmdCode == `FCS_CMD_ERASE_BLK) ? blockProt
							: addrProt) begin
							cmd.done     <= 1'b1;
							cmd.protViol <= 1'b1; // RL7
						end else begin
							state_q  <= fcs_pkg::FCS_ENG_EXEC;
							count_q  <= 16'(CMD_CYCLES - 1);
							cmd.busy <= 1'b1; // RL10
						end
					end
				end
				fcs_pkg::FCS_ENG_EXEC: begin
					if (count_q == 16'h0000) begin
						state_q   <= fcs_pkg::FCS_ENG_IDLE;
						cmd.busy  <= 1'b0; // RL10
						cmd.done  <= 1'b1; // RL3
						cmd.fault <= cmd.flashFault; // RL11
					end else begin
						count_q <= count_q - 16'h0001;
					end
				end
				default: begin
					state_q  <= fcs_pkg::FCS_ENG_IDLE;
					cmd.busy <= 1'b0;
				end
			endcase
		end
	end
endmodule // fcs_cmd_engine

/* File: verilog/fcs_ctrl_top.sv */
// fcs_ctrl_top.sv: flash command/status registers behind an AHB-Lite slave
// assumes: one clock, synchronous reset, single word transfers, one slave on the bus
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_ctrl_top #(
	parameter int CMD_CYCLES = `FCS_CMD_CYCLES
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// nonvolatile configuration and array status
	input  wire logic [7:0]  nvmProtByte,
	input  wire logic [1:0]  nvmResetFault,
	input  wire logic        flashFault,
	output logic [15:0]      nvmAddr,
	// debug mode
	input  wire logic        debugMode,
	// interrupt
	output logic             irq
);
	fcs_cmd_if cmdLink ();

	fcs_pkg::fcs_init_type initState_q;
	logic                  pend_q;
	logic                  pendWrite_q;
	logic                  pendOk_q;
	logic [15:0]           pendIdx_q;
	logic [`FCS_IDX_W-1:0] wordSel_q;
	logic                  irqEnable_q;
	logic                  cmdDone_q;
	logic                  access_error_flag_q;
	logic                  protViol_q;
	logic [`FCS_STAT_W-1:0] complStat_q;
	logic [7:0]            prot_q;
	logic [15:0]           words_q [`FCS_WORDS];
	logic [`FCS_EV_W-1:0]  evStat_q;
	logic [`FCS_EV_W-1:0]  evMask_q;
	logic                  launch_q;
	logic                  irq_q;
	logic                  hreadyout_q;
	logic [31:0]           hrdata_q;
	logic [15:0]           nvmAddr_q;
	logic                  addrPhase;
	logic                  wrStb;
	logic                  wrIndex;
	logic                  wrConfig;
	logic                  wrStatus;
	logic                  wrProt;
	logic                  wrData;
	logic                  wrEvStat;
	logic                  wrEvMask;
	logic                  launchOk;
	logic                  seqErr;
	logic                  wordOk;
	logic                  growOk;
	logic [7:0]            statusRd;
	logic [7:0]            protNew;
	logic [2:0]            oldLevel;
	logic [2:0]            newLevel;
	logic [`FCS_EV_W-1:0]  evSet;
	logic [31:0]           readMux;

	////////////////////////////////////////////////////////////////////////////
	// output ports straight from flip-flops
	assign hreadyout = hreadyout_q;
	assign hrdata    = hrdata_q;
	assign irq       = irq_q;
	assign nvmAddr   = nvmAddr_q;

	// response is never an error; held in a flip-flop for a clean start
	always_ff @(posedge clk) begin
		if (rst) begin
			hresp <= 1'b0;
		end else if (ce) begin
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset sequence: fetch the protection byte and reset-time fault status
	always_ff @(posedge clk) begin
		if (rst) begin
			initState_q <= fcs_pkg::FCS_INIT_LOAD;
			nvmAddr_q   <= `FCS_PROT_NV_ADDR;
		end else if (ce) begin
			case (initState_q)
				fcs_pkg::FCS_INIT_LOAD: initState_q <= fcs_pkg::FCS_INIT_RUN;
				fcs_pkg::FCS_INIT_RUN:  initState_q <= fcs_pkg::FCS_INIT_RUN;
				default:                initState_q <= fcs_pkg::FCS_INIT_LOAD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait state for every transfer so read data leaves a flip-flop
	assign addrPhase = hsel && htrans[1] && hready && !pend_q
		&& (initState_q == fcs_pkg::FCS_INIT_RUN);

	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q      <= 1'b0;
			pendWrite_q <= 1'b0;
			pendOk_q    <= 1'b0;
			pendIdx_q   <= 16'h0000;
			hreadyout_q <= 1'b0; // held low until the reset sequence is done
			hrdata_q    <= 32'h00000000;
		end else if (ce) begin
			if (addrPhase) begin
				pend_q      <= 1'b1;
				pendWrite_q <= hwrite;
				pendIdx_q   <= haddr[17:2];
				// only aligned whole words inside the register window are mapped
				pendOk_q    <= (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0)
					&& (hsize == `FCS_HSIZE_WORD);
				hreadyout_q <= 1'b0;
			end else if (pend_q) begin
				pend_q      <= 1'b0;
				hreadyout_q <= 1'b1;
				hrdata_q    <= pendWrite_q ? 32'h00000000 : readMux;
			end else if (initState_q == fcs_pkg::FCS_INIT_RUN) begin
				hreadyout_q <= 1'b1;
			end
		end
	end

	// write strobes, valid in the wait-state cycle of the data phase, where hwdata already stands
	assign wrStb    = pend_q && pendWrite_q && pendOk_q;
	assign wrIndex  = wrStb && (pendIdx_q == `FCS_IDX_CMD_INDEX);
	assign wrConfig = wrStb && (pendIdx_q == `FCS_IDX_CONFIG);
	assign wrStatus = wrStb && (pendIdx_q == `FCS_IDX_STATUS);
	assign wrProt   = wrStb && (pendIdx_q == `FCS_IDX_PROTECT);
	assign wrData   = wrStb && (pendIdx_q == `FCS_IDX_CMD_DATA);
	assign wrEvStat = wrStb && (pendIdx_q == `FCS_IDX_IRQ_STAT);
	assign wrEvMask = wrStb && (pendIdx_q == `FCS_IDX_IRQ_MASK);

	////////////////////////////////////////////////////////////////////////////
	// read mux; reserved bits and unmapped addresses read zero
	always_comb begin
		statusRd = 8'h00;
		statusRd[`FCS_BIT_DONE]   = cmdDone_q;
		statusRd[`FCS_BIT_ACCESS_ERROR_FLAG] = access_error_flag_q;
		statusRd[`FCS_BIT_PVIOL]  = protViol_q;
		statusRd[`FCS_BIT_BUSY]   = cmdLink.busy; // RL10
		statusRd[`FCS_STAT_W-1:0] = complStat_q;
		readMux = 32'h00000000;
		if (pendOk_q) begin
			case (pendIdx_q)
				`FCS_IDX_CMD_INDEX: readMux[`FCS_IDX_W-1:0] = wordSel_q; // RL1
				`FCS_IDX_CONFIG:    readMux[`FCS_BIT_IRQ_EN] = irqEnable_q;
				`FCS_IDX_STATUS:    readMux[7:0] = statusRd;
				`FCS_IDX_PROTECT:   readMux[7:0] = prot_q;
				`FCS_IDX_CMD_DATA: begin
					if (wordOk) begin
						readMux[15:0] = words_q[wordSel_q];
					end
				end
				`FCS_IDX_IRQ_STAT:  readMux[`FCS_EV_W-1:0] = evStat_q;
				`FCS_IDX_IRQ_MASK:  readMux[`FCS_EV_W-1:0] = evMask_q;
				default:            readMux = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// index and configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			wordSel_q   <= '0;
			irqEnable_q <= 1'b0;
		end else if (ce) begin
			if (wrIndex) begin
				wordSel_q <= hwdata[`FCS_IDX_W-1:0]; // RL1
			end
			if (wrConfig) begin
				irqEnable_q <= hwdata[`FCS_BIT_IRQ_EN];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command object array; a write out of sequence is an access error
	assign wordOk = (wordSel_q < `FCS_IDX_W'(`FCS_WORDS));
	assign seqErr = wrData && (!cmdDone_q || !wordOk) && !protViol_q; // RL4

	generate
		for (genvar w = 0; w < `FCS_WORDS; w++) begin : gWord
			always_ff @(posedge clk) begin
				if (rst) begin
					words_q[w] <= 16'h0000;
				end else if (ce) begin
					// no new sequence may start while a protection violation stands
					if (wrData && cmdDone_q && !protViol_q
						&& (wordSel_q == `FCS_IDX_W'(w))) begin // RL9
						words_q[w] <= hwdata[15:0];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// launch: a one written to the done flag, only with both error flags clear
	assign launchOk = wrStatus && hwdata[`FCS_BIT_DONE] && cmdDone_q
		&& !access_error_flag_q // RL5
		&& !protViol_q; // RL9

	always_ff @(posedge clk) begin
		if (rst) begin
			launch_q               <= 1'b0;
			cmdLink.cmdCode        <= 8'h00;
			cmdLink.cmdAddr        <= 16'h0000;
		end else if (ce) begin
			launch_q <= launchOk; // RL3
			if (launchOk) begin
				cmdLink.cmdCode <= words_q[0][15:8];
				cmdLink.cmdAddr <= words_q[1];
			end
		end
	end

	assign cmdLink.launch     = launch_q;
	assign cmdLink.protByte   = prot_q;
	assign cmdLink.flashFault = flashFault;

	////////////////////////////////////////////////////////////////////////////
	// status flags; a hardware set always wins over a software clear
	always_ff @(posedge clk) begin
		if (rst) begin
			cmdDone_q   <= 1'b1;
			access_error_flag_q    <= 1'b0;
			protViol_q  <= 1'b0;
			complStat_q <= '0;
		end else if (ce) begin
			if (initState_q == fcs_pkg::FCS_INIT_LOAD) begin
				complStat_q <= nvmResetFault; // RL11
			end else if (launchOk) begin
				complStat_q <= '0;
			end else if (cmdLink.fault) begin
				complStat_q[0] <= 1'b1; // RL11
			end
			// stays low from launch until the engine reports done or a violation
			if (launchOk) begin
				cmdDone_q <= 1'b0; // RL3
			end else if (cmdLink.done) begin
				cmdDone_q <= 1'b1; // RL3
			end
			if (seqErr || cmdLink.access_error_flag) begin
				access_error_flag_q <= 1'b1; // RL4
			end else if (wrStatus && hwdata[`FCS_BIT_ACCESS_ERROR_FLAG]) begin
				access_error_flag_q <= 1'b0; // RL6
			end
			if (cmdLink.protViol) begin
				protViol_q <= 1'b1; // RL7
			end else if (wrStatus && hwdata[`FCS_BIT_PVIOL]) begin
				protViol_q <= 1'b0; // RL8
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// protection register: loaded at reset, grow-only unless in debug mode
	// level 0 means no range, higher levels mean a larger range at the top
	assign protNew  = (prot_q & ~`FCS_PROT_WMASK) | (hwdata[7:0] & `FCS_PROT_WMASK);
	assign oldLevel = prot_q[`FCS_BIT_HIDIS] ? 3'h0
		: {1'b0, prot_q[`FCS_BIT_HSZ_HI:`FCS_BIT_HSZ_LO]} + 3'h1;
	assign newLevel = protNew[`FCS_BIT_HIDIS] ? 3'h0
		: {1'b0, protNew[`FCS_BIT_HSZ_HI:`FCS_BIT_HSZ_LO]} + 3'h1;

	// mode 1 protects the range, so it may only widen; mode 0 exempts it, so
	// it may only narrow; leaving mode 1 is safe only when nothing was protected
	always_comb begin
		growOk = 1'b0;
		if (prot_q[`FCS_BIT_MODE] == protNew[`FCS_BIT_MODE]) begin
			growOk = prot_q[`FCS_BIT_MODE] ? (newLevel >= oldLevel)
				: (newLevel <= oldLevel); // RL16
		end else if (prot_q[`FCS_BIT_MODE]) begin
			growOk = (oldLevel == 3'h0);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prot_q <= 8'h00;
		end else if (ce) begin
			if (initState_q == fcs_pkg::FCS_INIT_LOAD) begin
				prot_q <= nvmProtByte; // RL14
			end else if (wrProt && debugMode) begin
				prot_q <= protNew; // RL13
			end else if (wrProt && growOk) begin
				prot_q <= protNew; // RL12
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event status (write one to clear, set wins) and mask
	always_comb begin
		evSet = '0;
		evSet[`FCS_BIT_EV_DONE]   = cmdLink.done;
		evSet[`FCS_BIT_EV_ACCESS_ERROR_FLAG] = seqErr || cmdLink.access_error_flag;
		evSet[`FCS_BIT_EV_PVIOL]  = cmdLink.protViol;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			evStat_q <= '0;
			evMask_q <= '0;
		end else if (ce) begin
			if (wrEvStat) begin
				evStat_q <= (evStat_q & ~hwdata[`FCS_EV_W-1:0]) | evSet;
			end else begin
				evStat_q <= evStat_q | evSet;
			end
			if (wrEvMask) begin
				evMask_q <= hwdata[`FCS_EV_W-1:0];
			end
		end
	end

	// level interrupt, one cycle behind the flags it follows
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= (irqEnable_q && cmdDone_q) // RL2 RL17
				|| (|(evStat_q & evMask_q));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command engine
	fcs_cmd_engine #(
		.CMD_CYCLES (CMD_CYCLES),
		.RANGE_BASE (`FCS_RANGE_BASE)
	) uEngine (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.cmd (cmdLink)
	);
endmodule // fcs_ctrl_top

/* File: testbench/fcs_ctrl_properties.sv */
// fcs_ctrl_properties.sv: bus timing and read-back assertions of the flash control block
// assumes: bound to fcs_ctrl_top, ce high during transfers, single slave so hready is hreadyout
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_ctrl_properties #(
	parameter int CMD_CYCLES = `FCS_CMD_CYCLES
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// AHB-Lite
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// side outputs
	input wire logic [15:0] nvmAddr,
	input wire logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// accepted address phase, then exactly one wait state
	sequence addrPhase; hsel && htrans[1] && hready; endsequence
	sequence dataPhase; !hreadyout ##1 hreadyout; endsequence
	// word read of one register index
	sequence readOf(logic [15:0] idx);
		addrPhase ##0 (!hwrite && hsize == `FCS_HSIZE_WORD && haddr == {14'h0000, idx, 2'b00});
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	bus_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
	wait_state_a: assert property (addrPhase |=> dataPhase) else $error("wait state wrong");
	ready_idle_a: assert property (hreadyout && !(hsel && htrans[1]) |=> hreadyout)
		else $error("hreadyout dropped while idle");
	rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("hrdata moved without a transfer");
	// writes, odd sizes and far addresses answer zero
	zero_answer_a: assert property (addrPhase ##0 (hwrite || hsize != `FCS_HSIZE_WORD
		|| haddr[31:18] != 14'h0000) |=> dataPhase ##0 hrdata == 32'h00000000)
		else $error("nonzero answer");
	reset_quiet_a: assert property ($fell(rst) |-> !hreadyout && !irq ##[1:3] hreadyout)
		else $error("reset sequence wrong");
	nvm_addr_a: assert property (nvmAddr == `FCS_PROT_NV_ADDR)
		else $error("protection byte address wrong");
	index_upper_a: assert property (readOf(`FCS_IDX_CMD_INDEX) |=> dataPhase ##0
		hrdata[31:3] == 29'h00000000) else $error("index upper bits set");
	config_resv_a: assert property (readOf(`FCS_IDX_CONFIG) |=> dataPhase ##0
		(hrdata[31:8] == 24'h000000 && hrdata[6:0] == 7'h00)) else $error("config reserved");
	// busy never reads together with done
	status_bits_a: assert property (readOf(`FCS_IDX_STATUS) |=> dataPhase ##0
		(hrdata[31:8] == 24'h000000 && !hrdata[6] && !hrdata[2] && !(hrdata[3] && hrdata[7])))
		else $error("status bits wrong");
endmodule // fcs_ctrl_properties
bind fcs_ctrl_top fcs_ctrl_properties #(.CMD_CYCLES(CMD_CYCLES)) u_fcs_ctrl_properties (
	.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.nvmAddr(nvmAddr), .irq(irq));

/* File: testbench/tb_top.sv */
// tb_top.sv: self-checking bench of the flash command/status block over AHB-Lite
// assumes: fcs_ctrl_top with a short command time; the bench is the only bus master
`timescale 1ns/1ps
`include "fcs_cfg.svh"
`define CMP(nm, got, exp) begin checks++; if ((got) !== (exp)) begin errCount++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_top;
	localparam int CYC = 12;
	localparam logic [15:0] ST = `FCS_IDX_STATUS;
	localparam logic [15:0] PR = `FCS_IDX_PROTECT;
	localparam logic [15:0] DA = `FCS_IDX_CMD_DATA;
	typedef struct { logic [7:0] e; logic [7:0] m; string nm; } fcs_exp_type;
	// bench signals
	logic        clk, rst, hsel, hwrite, hreadyout, hresp, irq, flashFault, debugMode, rdPhase;
	logic        ce;
	logic [1:0]  htrans, nvmResetFault;
	logic [2:0]  hsize;
	logic [7:0]  nvmProtByte;
	logic [15:0] nvmAddr;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	int          errCount, checks, cyc;
	fcs_exp_type expQ[$];
	fcs_exp_type n;
	////////////////////////////////////////////////////////////////////////////////
	// clock and device
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	fcs_ctrl_top #(.CMD_CYCLES(CYC)) u_fcs_ctrl_top (
		.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nvmProtByte(nvmProtByte),
		.nvmResetFault(nvmResetFault), .flashFault(flashFault), .nvmAddr(nvmAddr),
		.debugMode(debugMode), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	// ready is looked at on the falling edge, where it has settled
	task automatic waitReady();
		@(negedge clk);
		while (hreadyout !== 1'b1) @(negedge clk);
		rdv = hrdata;
		@(posedge clk);
	endtask
	// one single word transfer, address phase held until ready
	task automatic bus(input logic [15:0] idx, input logic w, input logic [31:0] wd,
		input logic chk);
		hsel <= 1'b1;
		haddr <= {14'h0000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		rdPhase <= chk & ~w;
		waitReady();
		rdPhase <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
		bus(idx, 1'b1, wd, 1'b0);
	endtask
	// read with its expectation noted for the monitor
	task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [7:0] m,
		input string nm);
		expQ.push_back('{e & m, m, nm});
		bus(idx, 1'b0, 32'h00000000, 1'b1);
	endtask
	task automatic launch(input logic [7:0] code, input logic [15:0] addr);
		wr(`FCS_IDX_CMD_INDEX, 32'h00000000);
		wr(DA, {16'h0000, code, 8'h00});
		wr(`FCS_IDX_CMD_INDEX, 32'h00000001);
		wr(DA, {16'h0000, addr});
		wr(ST, 32'h00000080);
	endtask
	// polling is bounded; a command that never ends shows in the next status check
	task automatic waitDone();
		rdv = 32'h00000000;
		for (int i = 0; i < 40 && rdv[7] !== 1'b1; i++) bus(ST, 1'b0, 32'h00000000, 1'b0);
	endtask
	task automatic chkIrq(input logic e);
		@(negedge clk);
		`CMP("irq", irq, e)
		@(posedge clk);
	endtask
	task automatic endTest(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic finalReport();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// monitor: oldest note against each checked read answer
	always @(negedge clk) begin
		if (rdPhase === 1'b1 && hreadyout === 1'b1) begin
			n = expQ.pop_front();
			`CMP(n.nm, hrdata[7:0] & n.m, n.e)
		end
	end
	// a hang ends the run as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errCount++;
			finalReport();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{ce, rst, hsel, hwrite, flashFault, debugMode, rdPhase} = 7'b1100000;
		{htrans, haddr, hwdata, errCount, checks, cyc} = '0;
		hsize = `FCS_HSIZE_WORD;
		nvmResetFault = 2'b10;
		void'($urandom(32'h0744bc23));
		nvmProtByte = 8'hA0 | (8'($urandom()) & 8'h47);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		waitReady();
		rd(ST, 8'h82, 8'hFF, "status");
		rd(PR, nvmProtByte, 8'hFF, "protect");
		wr(`FCS_IDX_CMD_INDEX, 32'h000000FF);
		rd(`FCS_IDX_CMD_INDEX, 8'h07, 8'hFF, "index");
		rd(16'h0000, 8'h00, 8'hFF, "unmapped");
		endTest("reset");
		launch(8'hFF, 16'h7000);
		rd(ST, 8'hA0, 8'hF8, "status");
		wr(ST, 32'h00000080);
		rd(ST, 8'hA0, 8'hF8, "status");
		wr(ST, 32'h00000000);
		rd(ST, 8'hA0, 8'hF8, "status");
		wr(ST, 32'h00000020);
		rd(ST, 8'h80, 8'hF8, "status");
		endTest("access error");
		flashFault <= 1'b1;
		wr(`FCS_IDX_CONFIG, 32'h00000080);
		chkIrq(1'b1);
		launch(`FCS_CMD_PROGRAM, 16'h7000);
		ce <= 1'b0; // freeze while busy: the count must hold, else done would show
		repeat (20) @(posedge clk);
		ce <= 1'b1;
		rd(ST, 8'h08, 8'h88, "status");
		chkIrq(1'b0);
		waitDone();
		flashFault <= 1'b0;
		rd(ST, 8'h81, 8'h89, "status");
		chkIrq(1'b1);
		wr(`FCS_IDX_CONFIG, 32'h00000000);
		chkIrq(1'b0);
		rd(`FCS_IDX_IRQ_STAT, 8'h03, 8'h07, "events");
		wr(`FCS_IDX_IRQ_MASK, 32'h00000001);
		chkIrq(1'b1);
		wr(`FCS_IDX_IRQ_STAT, 32'h00000007);
		chkIrq(1'b0);
		endTest("command and interrupt");
		wr(PR, 32'h00000098);
		rd(PR, 8'h98 | (nvmProtByte & 8'h47), 8'hFF, "protect");
		wr(PR, 32'h000000B8);
		rd(PR, 8'h98 | (nvmProtByte & 8'h47), 8'hFF, "protect");
		launch(`FCS_CMD_PROGRAM, 16'h7000);
		rd(ST, 8'h90, 8'hF8, "status");
		wr(ST, 32'h00000080);
		wr(DA, 32'h00001234);
		rd(ST, 8'h90, 8'hF8, "status");
		rd(DA, 8'h00, 8'hFF, "data");
		wr(ST, 32'h00000000);
		rd(ST, 8'h90, 8'hF8, "status");
		wr(ST, 32'h00000010);
		rd(ST, 8'h80, 8'hF8, "status");
		launch(`FCS_CMD_ERASE_BLK, 16'h0000);
		rd(ST, 8'h90, 8'hF8, "status");
		wr(ST, 32'h00000010);
		debugMode <= 1'b1;
		wr(PR, 32'h00000018);
		debugMode <= 1'b0;
		rd(PR, 8'h18 | (nvmProtByte & 8'h47), 8'hFF, "protect");
		launch(`FCS_CMD_PROGRAM, 16'h6000 | 16'($urandom() & 32'h1FFF));
		waitDone();
		rd(ST, 8'h80, 8'hF8, "status");
		launch(`FCS_CMD_ERASE_SEC, 16'($urandom() & 32'h3FFF));
		rd(ST, 8'h90, 8'hF8, "status");
		endTest("protection");
		rst <= 1'b1;
		nvmResetFault <= 2'b00;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		waitReady();
		rd(ST, 8'h80, 8'hFF, "status");
		rd(PR, nvmProtByte, 8'hFF, "protect");
		endTest("second reset");
		finalReport();
	end
endmodule // tb_top
